// *** hw/esrm_pkg.sv ***
// Package for the engine status register bank: holding register numbers,
// command values, reset values, state codes and the structs that carry requests and faults.
// Assumes a frame engine outside that has already parsed each link request.
package esrm_pkg;

  // ==========================================================================
  // Holding register numbers, as seen by the link master.
  localparam logic [15:0] ESRM_ADDR_HOURS_HI = 16'h9c41;
  localparam logic [15:0] ESRM_ADDR_HOURS_LO = 16'h9c42;
  localparam logic [15:0] ESRM_ADDR_SPEED = 16'h9c43;
  localparam logic [15:0] ESRM_ADDR_VOLTS = 16'h9c44;
  localparam logic [15:0] ESRM_ADDR_OIL = 16'h9c45;
  localparam logic [15:0] ESRM_ADDR_TEMP = 16'h9c46;
  localparam logic [15:0] ESRM_ADDR_STATE = 16'h9c47;
  localparam logic [15:0] ESRM_ADDR_FLAGS_A = 16'h9c48;
  localparam logic [15:0] ESRM_ADDR_FLAGS_B = 16'h9c49;
  localparam logic [15:0] ESRM_ADDR_FLAGS_C = 16'h9c4a;
  localparam logic [15:0] ESRM_ADDR_SAVE = 16'h9d30;

  // ==========================================================================
  // Command values, node numbers and answer codes.
  localparam logic [15:0] ESRM_SAVE_VALUE = 16'h0001;
  localparam logic [7:0] ESRM_NODE_DEFAULT = 8'h01;
  localparam logic [7:0] ESRM_NODE_BROADCAST = 8'h00;
  localparam logic [7:0] ESRM_EXC_NONE = 8'h00;
  localparam logic [7:0] ESRM_EXC_BAD_ADDR = 8'h02;

  // ==========================================================================
  // Reset values of the bank's own state and the highest state code.
  localparam logic [15:0] ESRM_DATA_RESET = 16'h0000;
  localparam logic [31:0] ESRM_HOURS_RESET = 32'h0000_0000;
  localparam logic [4:0] ESRM_STATE_RESET_CODE = 5'h00;
  localparam logic [4:0] ESRM_STATE_MAX_CODE = 5'h10;

  // Sequencer states in the order of their reported numbers, 0 to 16.
  typedef enum logic [4:0] {
    ESRM_SEQ_ECU_STABILISE,
    ESRM_SEQ_STOPPED,
    ESRM_SEQ_STANDBY,
    ESRM_SEQ_PRESTART_1,
    ESRM_SEQ_SAFE_CHECK,
    ESRM_SEQ_PRESTART_2,
    ESRM_SEQ_CRANK,
    ESRM_SEQ_CRANK_REST,
    ESRM_SEQ_FALSE_START,
    ESRM_SEQ_WARMUP,
    ESRM_SEQ_LINE_FILL_1,
    ESRM_SEQ_LINE_FILL_2,
    ESRM_SEQ_RUN_LOADED,
    ESRM_SEQ_COOLDOWN,
    ESRM_SEQ_ETS_DELAY,
    ESRM_SEQ_SPINDOWN,
    ESRM_SEQ_WAIT_START
  } esrm_seq_t;

  // Active shutdown conditions, one bit each, high while active.
  typedef struct packed {
    logic overspeed;
    logic underspeed;
    logic overcrank;
    logic low_oil_press;
    logic high_eng_temp;
    logic low_fuel;
    logic low_disch_press;
    logic high_disch_press;
    logic no_speed_crank;
    logic low_lube;
    logic fuel_leak;
    logic fuel_filter;
    logic low_gbox_press_a;
    logic high_gbox_press_a;
    logic charger_fail;
    logic remote_stop;
    logic coolant_level;
    logic high_level;
    logic low_level;
    logic high_flow;
    logic low_flow;
    logic water_in_fuel;
    logic low_suction;
    logic high_suction;
    logic high_oil_temp;
    logic low_gbox_press_b;
    logic high_gbox_press_b;
    logic red_lamp;
    logic pivot_align;
    logic index_coolant;
    logic speed_lost_run;
  } esrm_faults_t;

  // One parsed register word of a link transaction.
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] node;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } esrm_req_t;

  // Answer to one register word.
  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [15:0] data;
  } esrm_rsp_t;

endpackage

// *** hw/esrm_hours_snap.sv ***
// Holds a copy of the 32-bit engine hours for the span of one transaction.
// Assumes the capture pulse comes on the first word of each transaction.
`timescale 1ns/1ps

module esrm_hours_snap (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Live counter and capture pulse.
  input wire logic [31:0] hours_live,
  input wire logic capture,
  // Copy seen by the register bank.
  output logic [31:0] hours_view
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [31:0] hold;
  } esrm_snap_state_t;

  esrm_snap_state_t s_q;
  esrm_snap_state_t s_d;

  // RULE_21: coherent hours capture.
  // Both halves come from one copy taken at the start of the transaction.
  always_comb begin
    s_d = s_q;
    if (capture) begin
      s_d.hold = hours_live;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.hold <= esrm_pkg::ESRM_HOURS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // The capturing word itself must already see the fresh value.
  assign hours_view = capture ? hours_live : s_q.hold;

endmodule

// *** hw/esrm_bank.sv ***
// Engine status register bank answering parsed link requests word by word.
// Assumes an outside frame engine delivers one register word per request
// and that all live inputs come from logic on the same clock.
//
// What this block does
// RULE_01: Engine hours read-only over two registers.
// RULE_02: Supply voltage register reads tenths of volt.
// RULE_03: Speed, oil pressure, temperature follow voltage.
// RULE_04: One read-only active sequencer state number.
// RULE_05: Idle states encode as 0, 1, 2.
// RULE_06: Starting states encode as 3 through 8.
// RULE_07: Warm-up, line fills, running encode 9-12.
// RULE_08: Stopping states encode as 13 through 16.
// RULE_09: Fault bit reads one while fault active.
// RULE_10: First bitmap bits 0-3 engine faults.
// RULE_11: First bitmap bits 4-8 further faults.
// RULE_12: First bitmap bits 9-15 remaining faults.
// RULE_13: Second bitmap bits 0-4; 5,6 reserved.
// RULE_14: Second bitmap bits 7-9, 11; 10 reserved.
// RULE_15: Second bitmap gearbox, reserved, red lamp.
// RULE_16: Third bitmap bits 0-2; rest reserved.
// RULE_17: Link writes temporary, lost at power cycle.
// RULE_18: Writing one to save register commits.
// RULE_19: Answer only at configured node number.
// RULE_20: Reserved reads zero, read-only writes ignored.
// RULE_21: Hours halves captured coherently per transaction.
`timescale 1ns/1ps

module esrm_bank (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Live engine values.
  input wire logic [31:0] hours_live,
  input wire logic [15:0] speed_rpm,
  input wire logic [15:0] volts_tenths,
  input wire logic [15:0] oil_kpa,
  input wire logic [15:0] temp_c,
  input wire logic [4:0] seq_code,
  input wire esrm_pkg::esrm_faults_t faults,
  // Link configuration from the front panel.
  input wire logic [7:0] node_addr,
  input wire logic modbus_sel,
  // Parsed requests and their answers.
  input wire esrm_pkg::esrm_req_t req,
  output esrm_pkg::esrm_rsp_t rsp,
  // Non-volatile commit strobe.
  output logic nv_commit
);

  // ==========================================================================
  // State.
  typedef struct packed {
    esrm_pkg::esrm_rsp_t rsp;
    logic nv_commit;
    logic [4:0] seq;
  } esrm_bank_state_t;

  esrm_bank_state_t s_q;
  esrm_bank_state_t s_d;
  logic [31:0] hours_view;
  logic capture;
  logic for_us;
  logic broadcast;

  // ==========================================================================
  // Address decode; the save match is used by both the read and the write path, the status range by the read path.
  function automatic logic esrm_is_status(input logic [15:0] addr);
    esrm_is_status = (addr >= esrm_pkg::ESRM_ADDR_HOURS_HI) &&
                     (addr <= esrm_pkg::ESRM_ADDR_FLAGS_C);
  endfunction

  function automatic logic esrm_is_save(input logic [15:0] addr);
    esrm_is_save = (addr == esrm_pkg::ESRM_ADDR_SAVE);
  endfunction

  // ==========================================================================
  // Bitmap packing; unlisted positions stay zero.
  function automatic logic [15:0] esrm_flags_a(input esrm_pkg::esrm_faults_t f);
    logic [15:0] v;
    v = 16'h0000;
    // RULE_10: bits 0 to 3.
    v[0] = f.overspeed;
    v[1] = f.underspeed;
    v[2] = f.overcrank;
    v[3] = f.low_oil_press;
    // RULE_11: bits 4 to 8.
    v[4] = f.high_eng_temp;
    v[5] = f.low_fuel;
    v[6] = f.low_disch_press;
    v[7] = f.high_disch_press;
    v[8] = f.no_speed_crank;
    // RULE_12: bits 9 to 15.
    v[9] = f.low_lube;
    v[10] = f.fuel_leak;
    v[11] = f.fuel_filter;
    v[12] = f.low_gbox_press_a;
    v[13] = f.high_gbox_press_a;
    v[14] = f.charger_fail;
    v[15] = f.remote_stop;
    esrm_flags_a = v;
  endfunction

  function automatic logic [15:0] esrm_flags_b(input esrm_pkg::esrm_faults_t f);
    logic [15:0] v;
    v = 16'h0000;
    // RULE_13: bits 0 to 4, 5 and 6 reserved.
    v[0] = f.coolant_level;
    v[1] = f.high_level;
    v[2] = f.low_level;
    v[3] = f.high_flow;
    v[4] = f.low_flow;
    // RULE_14: bits 7 to 9 and 11.
    v[7] = f.water_in_fuel;
    v[8] = f.low_suction;
    v[9] = f.high_suction;
    v[11] = f.high_oil_temp;
    // RULE_15: gearbox pair and red lamp.
    v[12] = f.low_gbox_press_b;
    v[13] = f.high_gbox_press_b;
    v[15] = f.red_lamp;
    esrm_flags_b = v;
  endfunction

  function automatic logic [15:0] esrm_flags_c(input esrm_pkg::esrm_faults_t f);
    logic [15:0] v;
    v = 16'h0000;
    // RULE_16: bits 0 to 2 only.
    v[0] = f.pivot_align;
    v[1] = f.index_coolant;
    v[2] = f.speed_lost_run;
    esrm_flags_c = v;
  endfunction

  // ==========================================================================
  // Sequencer state numbers; a code outside this list names no state.
  // The enum lists the states in reported order, so its value is the number.
  function automatic logic esrm_seq_known(input logic [4:0] code);
    esrm_seq_known = 1'b0;
    case (code)
      // RULE_05: idle states 0 to 2.
      esrm_pkg::ESRM_SEQ_ECU_STABILISE,
      esrm_pkg::ESRM_SEQ_STOPPED,
      esrm_pkg::ESRM_SEQ_STANDBY: begin
        esrm_seq_known = 1'b1;
      end
      // RULE_06: starting states 3 to 8.
      esrm_pkg::ESRM_SEQ_PRESTART_1,
      esrm_pkg::ESRM_SEQ_SAFE_CHECK,
      esrm_pkg::ESRM_SEQ_PRESTART_2,
      esrm_pkg::ESRM_SEQ_CRANK,
      esrm_pkg::ESRM_SEQ_CRANK_REST,
      esrm_pkg::ESRM_SEQ_FALSE_START: begin
        esrm_seq_known = 1'b1;
      end
      // RULE_07: warm-up, line fills, running 9 to 12.
      esrm_pkg::ESRM_SEQ_WARMUP,
      esrm_pkg::ESRM_SEQ_LINE_FILL_1,
      esrm_pkg::ESRM_SEQ_LINE_FILL_2,
      esrm_pkg::ESRM_SEQ_RUN_LOADED: begin
        esrm_seq_known = 1'b1;
      end
      // RULE_08: stopping states 13 to 16.
      esrm_pkg::ESRM_SEQ_COOLDOWN,
      esrm_pkg::ESRM_SEQ_ETS_DELAY,
      esrm_pkg::ESRM_SEQ_SPINDOWN,
      esrm_pkg::ESRM_SEQ_WAIT_START: begin
        esrm_seq_known = 1'b1;
      end
      default: begin
        esrm_seq_known = 1'b0;
      end
    endcase
  endfunction

  // ==========================================================================
  // Node match and hours snapshot.
  // RULE_19: node number filter.
  // Broadcast writes are taken but never answered, as the link expects.
  assign broadcast = req.node == esrm_pkg::ESRM_NODE_BROADCAST;
  assign for_us = req.valid && modbus_sel && (req.node == node_addr);
  assign capture = for_us && req.first;

  esrm_hours_snap u_hours (
    .clk(clk),
    .rst_n(rst_n),
    .hours_live(hours_live),
    .capture(capture),
    .hours_view(hours_view)
  );

  // ==========================================================================
  // A word is taken on the edge at which it is valid and addressed to us.
  // Its answer stands for exactly the following cycle and then drops.
  // Words may follow back to back, so nothing but the last state code and
  // the hours copy carries over from one word to the next.
  // Live values are read in the cycle of their own word, not frozen for the
  // whole transaction. Only the hours pair needs a coherent copy, and a copy
  // of every register would cost far more flops than a master could notice.
  // A broadcast write gets no answer, so a master cannot learn from it
  // whether a save reached this node; it must use an addressed write for that.
  // Next state: one answer per word addressed to us, one cycle after it.
  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.rsp.exc = esrm_pkg::ESRM_EXC_NONE;
    s_d.rsp.data = esrm_pkg::ESRM_DATA_RESET;
    s_d.nv_commit = 1'b0;
    // RULE_04: hold the last valid state code.
    // A code past the last state would name no state, so it is not taken.
    if (esrm_seq_known(seq_code)) begin
      s_d.seq = seq_code;
    end
    if (for_us && !req.write) begin
      s_d.rsp.valid = 1'b1;
      if (esrm_is_status(req.addr)) begin
        case (req.addr)
          // RULE_01: hours, high half first.
          esrm_pkg::ESRM_ADDR_HOURS_HI: begin
            s_d.rsp.data = hours_view[31:16];
          end
          esrm_pkg::ESRM_ADDR_HOURS_LO: begin
            s_d.rsp.data = hours_view[15:0];
          end
          // RULE_03: speed in RPM.
          esrm_pkg::ESRM_ADDR_SPEED: begin
            s_d.rsp.data = speed_rpm;
          end
          // RULE_02: voltage in tenths.
          esrm_pkg::ESRM_ADDR_VOLTS: begin
            s_d.rsp.data = volts_tenths;
          end
          // RULE_03: oil and temperature.
          esrm_pkg::ESRM_ADDR_OIL: begin
            s_d.rsp.data = oil_kpa;
          end
          esrm_pkg::ESRM_ADDR_TEMP: begin
            s_d.rsp.data = temp_c;
          end
          // RULE_05: state number readout.
          // RULE_06: encoding follows enum.
          // RULE_07: encoding follows enum.
          // RULE_08: encoding follows enum.
          esrm_pkg::ESRM_ADDR_STATE: begin
            s_d.rsp.data = {11'h000, s_q.seq};
          end
          // RULE_09: active fault reads one.
          esrm_pkg::ESRM_ADDR_FLAGS_A: begin
            s_d.rsp.data = esrm_flags_a(faults);
          end
          esrm_pkg::ESRM_ADDR_FLAGS_B: begin
            s_d.rsp.data = esrm_flags_b(faults);
          end
          esrm_pkg::ESRM_ADDR_FLAGS_C: begin
            s_d.rsp.data = esrm_flags_c(faults);
          end
          default: begin
            s_d.rsp.data = esrm_pkg::ESRM_DATA_RESET;
          end
        endcase
      end else if (esrm_is_save(req.addr)) begin
        // RULE_20: write-only command reads zero.
        s_d.rsp.data = esrm_pkg::ESRM_DATA_RESET;
      end else begin
        s_d.rsp.exc = esrm_pkg::ESRM_EXC_BAD_ADDR;
      end
    end
    if (req.valid && modbus_sel && req.write && (for_us || broadcast)) begin
      s_d.rsp.valid = for_us;
      s_d.rsp.data = req.wdata;
      if (esrm_is_save(req.addr)) begin
        // RULE_18: one commits pending changes.
        // Other values are acknowledged and do nothing.
        s_d.nv_commit = req.wdata == esrm_pkg::ESRM_SAVE_VALUE;
      end else begin
        // RULE_20: read-only writes refused.
        // Nothing is stored; the master gets an address exception.
        s_d.rsp.exc = esrm_pkg::ESRM_EXC_BAD_ADDR;
        s_d.rsp.data = esrm_pkg::ESRM_DATA_RESET;
      end
    end
  end

  // RULE_17: nothing from the link survives reset.
  // The bank keeps no copy of link writes, so a power cycle leaves only the
  // panel values held outside; keeping them needs the commit strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.rsp.valid <= 1'b0;
      s_q.rsp.exc <= esrm_pkg::ESRM_EXC_NONE;
      s_q.rsp.data <= esrm_pkg::ESRM_DATA_RESET;
      s_q.nv_commit <= 1'b0;
      s_q.seq <= esrm_pkg::ESRM_STATE_RESET_CODE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops.
  assign rsp = s_q.rsp;
  assign nv_commit = s_q.nv_commit;

endmodule

// *** tb/esrm_bank_assertions.sv ***
// Checker for the register bank, watching only its ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps

module esrm_bank_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Live values.
  input wire logic [31:0] hours_live,
  input wire logic [15:0] speed_rpm,
  input wire logic [15:0] volts_tenths,
  input wire esrm_pkg::esrm_faults_t faults,
  // Link side.
  input wire logic [7:0] node_addr,
  input wire logic modbus_sel,
  input wire esrm_pkg::esrm_req_t req,
  input wire esrm_pkg::esrm_rsp_t rsp,
  input wire logic nv_commit
);
  // ====
  // Helpers.
  logic take;
  logic save_req;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A broadcast read is not taken, so node zero is excluded here.
  assign take = req.valid && modbus_sel && req.node == node_addr && req.node != 8'h00;
  assign save_req = req.valid && modbus_sel && req.write && req.wdata == 16'h0001 &&
    req.addr == esrm_pkg::ESRM_ADDR_SAVE && (req.node == node_addr || req.node == 8'h00);
  sequence s_read(logic [15:0] a);
    take && !req.write && req.addr == a;
  endsequence
  sequence s_hours_first;
    take && !req.write && req.first && req.addr == esrm_pkg::ESRM_ADDR_HOURS_HI;
  endsequence
  // ====
  // Properties.
  chk_answer_taken: assert property (take |=> rsp.valid)
    else $error("taken request got no answer");
  chk_foreign_node: assert property (req.valid && (!modbus_sel || (req.node != node_addr
    && req.node != 8'h00)) |=> !rsp.valid) else $error("foreign request answered");
  chk_hours_live: assert property (
    s_hours_first |=> rsp.data == $past(hours_live[31:16]))
    else $error("hours upper half wrong");
  chk_speed_value: assert property (
    s_read(esrm_pkg::ESRM_ADDR_SPEED) |=> rsp.data == $past(speed_rpm))
    else $error("speed value wrong");
  chk_volts_value: assert property (
    s_read(esrm_pkg::ESRM_ADDR_VOLTS) |=> rsp.data == $past(volts_tenths))
    else $error("voltage value wrong");
  chk_flags_c: assert property (
    s_read(esrm_pkg::ESRM_ADDR_FLAGS_C) |=> rsp.data == {13'h0000,
    $past(faults.speed_lost_run), $past(faults.index_coolant), $past(faults.pivot_align)})
    else $error("third bitmap wrong");
  chk_ro_write: assert property (
    take && req.write && req.addr != esrm_pkg::ESRM_ADDR_SAVE
    |=> rsp.exc == 8'h02 && rsp.data == 16'h0000) else $error("read-only write accepted");
  chk_save_commit: assert property (save_req |=> nv_commit)
    else $error("save command without commit");
  chk_commit_cause: assert property (nv_commit |-> $past(save_req))
    else $error("commit without save command");
endmodule

bind esrm_bank esrm_bank_assertions u_chk (.clk(clk), .rst_n(rst_n), .hours_live(hours_live),
  .speed_rpm(speed_rpm), .volts_tenths(volts_tenths), .faults(faults), .node_addr(node_addr),
  .modbus_sel(modbus_sel), .req(req), .rsp(rsp), .nv_commit(nv_commit));

// *** tb/esrm_master.sv ***
// Link master model issuing parsed register words to the bank.
// Assumes the caller serialises calls, one word per clock edge.
`timescale 1ns/1ps

module esrm_master (
  // Clock.
  input wire logic clk,
  // Request toward the bank.
  output esrm_pkg::esrm_req_t req
);
  esrm_pkg::esrm_req_t r;
  initial req = '0;
  // ====
  // one register word issued
  task word(input logic first, input logic [7:0] node, input logic wr,
            input logic [15:0] addr, input logic [15:0] wdata);
    @(posedge clk);
    req <= {1'b1, first, node, wr, addr, wdata};
  endtask
  // Released fields flip so a stale word is never mistaken for a live one.
  task idle();
    @(posedge clk);
    r = ~req;
    r.valid = 1'b0;
    req <= r;
  endtask
endmodule

// *** tb/esrm_bank_tb.sv ***
// Self-checking bench for the register bank with a queue of expected answers.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module esrm_bank_tb;
  typedef struct packed {logic v; logic [7:0] exc; logic [15:0] data; logic commit;} esrm_note_t;
  logic clk, rst_n, modbus_sel, nv_commit;
  logic [31:0] hours_live, h;
  logic [15:0] speed_rpm, volts_tenths, oil_kpa, temp_c, lfsr_q, r1, r2;
  logic [4:0] seq_code;
  logic [7:0] node_addr;
  esrm_pkg::esrm_faults_t faults;
  esrm_pkg::esrm_req_t req;
  esrm_pkg::esrm_rsp_t rsp;
  esrm_note_t notes[$];
  esrm_note_t n;
  int fail_count, n_checks;
  esrm_bank dut (.clk(clk), .rst_n(rst_n), .hours_live(hours_live), .speed_rpm(speed_rpm),
    .volts_tenths(volts_tenths), .oil_kpa(oil_kpa), .temp_c(temp_c), .seq_code(seq_code),
    .faults(faults), .node_addr(node_addr), .modbus_sel(modbus_sel), .req(req), .rsp(rsp),
    .nv_commit(nv_commit));
  esrm_master master (.clk(clk), .req(req));
  // ====
  // Helpers.
  function logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  function esrm_note_t ok(input logic [15:0] d);
    return {1'b1, 8'h00, d, 1'b0};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task ask(input logic f, input logic [7:0] nd, input logic wr, input logic [15:0] a,
           input logic [15:0] wd, input esrm_note_t e);
    master.word(f, nd, wr, a, wd);
    if (e.v || e.commit) notes.push_back(e);
  endtask
  task finish_test();
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Each answer or commit strobe is matched against the oldest note.
  always @(posedge clk) begin
    if (rst_n && (rsp.valid || nv_commit)) begin
      n = notes.pop_front();
      check({rsp.valid, nv_commit}, {n.v, n.commit}, "answer strobes");
      if (n.v) check({rsp.exc, rsp.data}, {n.exc, n.data}, "answer value");
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  // ====
  // Main sequence.
  initial begin
    {rst_n, hours_live, speed_rpm, volts_tenths, oil_kpa, temp_c, seq_code, faults} = '0;
    modbus_sel = 1'b1;
    node_addr = esrm_pkg::ESRM_NODE_DEFAULT;
    lfsr_q = 16'h005f;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      // The idle word keeps the new live values off the last word of the previous pass.
      master.idle();
      r1 = rnd();
      r2 = rnd();
      {hours_live, speed_rpm, volts_tenths} <= {r1, r2, rnd(), rnd() ^ r1};
      {oil_kpa, temp_c, faults} <= {r2, rnd(), r1[14:0], rnd()};
      seq_code <= 5'(i % 17);
      h = {r1, r2};
      ask(1'b1, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_HOURS_HI, '0, ok(h[31:16]));
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_HOURS_LO, '0, ok(h[15:0]));
      hours_live <= ~h;
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_SPEED, '0, ok(speed_rpm));
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_VOLTS, '0, ok(volts_tenths));
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_OIL, '0, ok(oil_kpa));
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_TEMP, '0, ok(temp_c));
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_STATE, '0, ok(16'(i % 17)));
      for (int k = 0; k < 16; k++) r1[k] = faults[30-k];
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_FLAGS_A, '0, ok(r1));
      r2 = {faults[3], 1'b0, faults[4], faults[5], faults[6], 1'b0, faults[7], faults[8],
            faults[9], 2'b00, faults[10], faults[11], faults[12], faults[13], faults[14]};
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_FLAGS_B, '0, ok(r2));
      ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_FLAGS_C, '0,
          ok({13'h0, faults[0], faults[1], faults[2]}));
    end
    // An out-of-range state code must leave the last reported state alone.
    seq_code <= 5'h1f;
    master.idle();
    master.idle();
    ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_STATE, '0, ok(16'h0002));
    // A strobe set just after a call stands with the word that call put out.
    ask(1'b0, 8'h07, 1'b0, esrm_pkg::ESRM_ADDR_SPEED, '0, '0);
    ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_SPEED, '0, '0);
    modbus_sel <= 1'b0;
    ask(1'b0, 8'h00, 1'b0, esrm_pkg::ESRM_ADDR_SPEED, '0, '0);
    modbus_sel <= 1'b1;
    ask(1'b0, 8'h01, 1'b0, 16'h9c40, '0, {1'b1, 8'h02, 16'h0000, 1'b0});
    ask(1'b0, 8'h01, 1'b0, 16'h9c4b, '0, {1'b1, 8'h02, 16'h0000, 1'b0});
    ask(1'b0, 8'h01, 1'b1, esrm_pkg::ESRM_ADDR_SPEED, 16'h1234,
        {1'b1, 8'h02, 16'h0, 1'b0});
    ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_SPEED, '0, ok(speed_rpm));
    ask(1'b0, 8'h01, 1'b1, esrm_pkg::ESRM_ADDR_SAVE, 16'h0002, ok(16'h0002));
    ask(1'b0, 8'h01, 1'b1, esrm_pkg::ESRM_ADDR_SAVE, 16'h0001,
        {1'b1, 8'h00, 16'h1, 1'b1});
    ask(1'b0, 8'h00, 1'b1, esrm_pkg::ESRM_ADDR_SAVE, 16'h0001,
        {1'b0, 8'h00, 16'h0, 1'b1});
    ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_SAVE, '0, ok(16'h0000));
    ask(1'b0, 8'h05, 1'b0, esrm_pkg::ESRM_ADDR_VOLTS, '0, ok(volts_tenths));
    node_addr <= 8'h05;
    ask(1'b0, 8'h01, 1'b0, esrm_pkg::ESRM_ADDR_VOLTS, '0, '0);
    master.idle();
    repeat (4) @(posedge clk);
    check(notes.size(), 0, "answers missing");
    finish_test();
  end
endmodule
